/* File: rtl/fhi_defs.svh */
// constants of the fir host interface: widths, depths, counts, reset values
// assumes nothing; included by the package only
`ifndef FHI_DEFS_SVH
`define FHI_DEFS_SVH

`define FHI_DW 16
`define FHI_CW 16
`define FHI_OW 36
`define FHI_RW 4
`define FHI_TAPS 8
`define FHI_HALF_TAPS 4
`define FHI_HIST 16
`define FHI_STRIDE_MC 2
`define FHI_FIFO_W 33
`define FHI_FIFO_D 8
`define FHI_FIFO_AW 3
`define FHI_RECFG_CYC 3'h4
`define FHI_RATIO_RST 4'h1
`define FHI_WR_MAX 5'h1f
`define FHI_HB_LAST_EVEN 5'h0c
`define FHI_HB_CENTRE 5'h0d

`endif

/* File: rtl/fhi_dev_end.sv */
// filter end: input fifo, 8-tap fir, ratio and coefficient reload control
// assumes one clock, sources on the link synchronous to it
//
// What this block does
// - low speed: one input lane, one output lane
// - high speed: two lanes each way, interleaved
// - source marks channel 0 input sample
// - channel 0 output marked in same cycle
// - ratio captured when load strobe high
// - ready-for-input drops while ratio reconfigures
// - new ratio applies once ready returns
// - whole coefficient set sent as one batch
// - write strobe held high for whole batch
// - one-clock commit switches to new set
// - without reorder, source sends pre-ordered set
// - ready low after reset until commit
// - reorder logic accepts natural coefficient order
// - symmetric reorder keeps first half only
// - half-band reorder keeps even positions up to 12 plus the centre at 13, drops the rest
// - even samples lane one, odd lane two
// - new sample only after ready seen high
// - samples taken only when input valid high
// - output valid exactly with valid result
`timescale 1ns/1ps

// ************************************************************
// input buffer
// ************************************************************
module fhi_fifo #(
    parameter int W = `FHI_FIFO_W,
    parameter int D = `FHI_FIFO_D,
    parameter int AW = `FHI_FIFO_AW
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic en,
    input wire logic clr,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [AW:0] level
);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } fhi_fifo_s_t;

    fhi_fifo_s_t s_reg;
    fhi_fifo_s_t s_next;
    logic push;
    logic pop;

    assign in_ready = (s_reg.cnt != (AW+1)'(D)) && en;
    assign out_valid = (s_reg.cnt != '0) && en;
    assign out_data = s_reg.mem[s_reg.rp];
    assign level = s_reg.cnt;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // pointers wrap naturally: depth is a power of two
    always_comb begin
        s_next = s_reg;
        if (en) begin
            if (clr) begin
                s_next = '0;
            end else begin
                if (push) begin
                    s_next.mem[s_reg.wp] = in_data;
                    s_next.wp = s_reg.wp + 1'b1;
                end
                if (pop) begin
                    s_next.rp = s_reg.rp + 1'b1;
                end
                s_next.cnt = s_reg.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule // fhi_fifo

// ************************************************************
// filter end
// ************************************************************
module fhi_dev_end (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    input wire logic sync_clear,
    input wire logic cfg_high_speed,
    input wire logic cfg_multi_chan,
    input wire logic cfg_reorder,
    input wire logic cfg_symmetric,
    input wire logic cfg_half_band,
    fhi_link.dev link
);
    import fhi_pkg::*;

    function automatic fhi_dev_s_t dev_rst();
        fhi_dev_s_t r;
        r = '0;
        r.st = DS_WAIT;
        r.ratio = `FHI_RATIO_RST;
        return r;
    endfunction

    localparam fhi_dev_s_t DEV_RST = dev_rst();

    function automatic fhi_res_t fir_at(input fhi_hist_t h, input fhi_taps_t c,
                                        input int off, input int stride);
        fhi_res_t acc;
        acc = '0;
        for (int k = 0; k < `FHI_TAPS; k++) begin
            acc = acc + fhi_res_t'(h[off + k * stride] * c[k]);
        end
        return acc;
    endfunction

    // which natural-order positions are stored when reordering
    function automatic logic coef_keep(input logic reo, input logic sym, input logic hb,
                                       input logic [4:0] n);
        if (reo && hb) begin
            return (!n[0] && n <= `FHI_HB_LAST_EVEN) || (n == `FHI_HB_CENTRE);
        end else if (reo && sym) begin
            return n < 5'(`FHI_HALF_TAPS);
        end
        return n < 5'(`FHI_TAPS);
    endfunction

    function automatic logic [2:0] coef_slot(input logic reo, input logic hb,
                                            input logic [4:0] n);
        if (reo && hb) begin
            return (n == `FHI_HB_CENTRE) ? 3'(`FHI_TAPS - 1) : n[3:1];
        end
        return n[2:0];
    endfunction

    fhi_dev_s_t s_reg;
    fhi_dev_s_t s_next;
    fhi_word_t word;
    fhi_word_t in_word;
    logic [`FHI_FIFO_W-1:0] f_data;
    logic f_valid;
    logic pop;
    logic [`FHI_FIFO_AW:0] f_level;
    int stride;
    logic [2:0] slot;

    assign in_word = '{first: link.in_first, q: link.in_q, i: link.in_i};
    assign stride = cfg_multi_chan ? `FHI_STRIDE_MC : 1;

    // ************************************************************
    // input path
    // ************************************************************
    fhi_fifo #(
        .W(`FHI_FIFO_W),
        .D(`FHI_FIFO_D),
        .AW(`FHI_FIFO_AW)
    ) i_fhi_fifo (
        .clock(clock),
        .nrst(nrst),
        .en(ce),
        .clr(sync_clear),
        .in_valid(link.in_valid),
        .in_ready(),
        .in_data(in_word),
        .out_valid(f_valid),
        .out_ready(pop),
        .out_data(f_data),
        .level(f_level)
    );

    // two slots spare: a sample may follow one cycle after ready falls
    assign link.rdy = (s_reg.st == DS_RUN) && (f_level <= 4'(`FHI_FIFO_D - 2));
    assign pop = (s_reg.st == DS_RUN) && f_valid;
    assign word = fhi_word_t'(f_data);
    assign slot = coef_slot(cfg_reorder, cfg_half_band, s_reg.wr_cnt);

    // ************************************************************
    // control and datapath
    // ************************************************************
    always_comb begin
        s_next = s_reg;
        if (ce) begin
            s_next.out_valid = 1'b0;
            if (sync_clear) begin
                s_next = DEV_RST;
            end else begin
                // shadow set only; taps untouched until commit
                if (link.cf_we) begin
                    if (coef_keep(cfg_reorder, cfg_symmetric, cfg_half_band, s_reg.wr_cnt)) begin
                        s_next.shadow[slot] = link.cf_data;
                        if (cfg_reorder && cfg_symmetric && !cfg_half_band) begin
                            s_next.shadow[3'(`FHI_TAPS - 1) - slot] = link.cf_data;
                        end
                    end
                    if (s_reg.wr_cnt != `FHI_WR_MAX) begin
                        s_next.wr_cnt = s_reg.wr_cnt + 5'h01;
                    end
                end
                if (link.cf_commit) begin
                    s_next.taps = s_reg.shadow;
                    s_next.wr_cnt = '0;
                    s_next.coef_ok = 1'b1;
                end
                case (s_reg.st)
                    DS_WAIT: begin
                        if (s_next.coef_ok) begin
                            s_next.st = DS_RUN;
                        end
                    end
                    DS_RUN: begin
                        if (pop) begin
                            if (cfg_high_speed) begin
                                s_next.hist = {s_reg.hist[`FHI_HIST-3:0], word.i, word.q};
                                s_next.out_i = fir_at(s_next.hist, s_reg.taps, 1, stride);
                                s_next.out_q = fir_at(s_next.hist, s_reg.taps, 0, stride);
                            end else begin
                                s_next.hist = {s_reg.hist[`FHI_HIST-2:0], word.i};
                                s_next.out_i = fir_at(s_next.hist, s_reg.taps, 0, stride);
                                s_next.out_q = '0;
                            end
                            s_next.out_first = cfg_multi_chan && word.first;
                            s_next.out_valid = (s_reg.dec_cnt == '0);
                            if (s_reg.dec_cnt + 4'h1 >= s_reg.ratio) begin
                                s_next.dec_cnt = '0;
                            end else begin
                                s_next.dec_cnt = s_reg.dec_cnt + 4'h1;
                            end
                        end
                    end
                    DS_RECFG: begin
                        if (s_reg.recfg_cnt == '0) begin
                            s_next.st = s_next.coef_ok ? DS_RUN : DS_WAIT;
                        end else begin
                            s_next.recfg_cnt = s_reg.recfg_cnt - 3'h1;
                        end
                    end
                    default: begin
                        s_next.st = DS_WAIT;
                    end
                endcase
                if (link.ratio_load) begin
                    s_next.ratio = link.ratio;
                    s_next.dec_cnt = '0;
                    s_next.recfg_cnt = `FHI_RECFG_CYC - 3'h1;
                    s_next.st = DS_RECFG;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_reg <= DEV_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign link.out_valid = s_reg.out_valid;
    assign link.out_i = s_reg.out_i;
    assign link.out_q = s_reg.out_q;
    assign link.out_first = s_reg.out_first;
endmodule // fhi_dev_end

/* File: rtl/fhi_host_end.sv */
// source and sink end: registers samples, coefficients and ratio onto the link
// assumes one clock shared with the filter end
`timescale 1ns/1ps

module fhi_host_end (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    input wire logic usr_smp_valid,
    output logic usr_smp_ready,
    input wire fhi_pkg::fhi_smp_t usr_smp_i,
    input wire fhi_pkg::fhi_smp_t usr_smp_q,
    input wire logic usr_smp_first,
    input wire logic usr_cf_valid,
    output logic usr_cf_ready,
    input wire fhi_pkg::fhi_coef_t usr_cf_data,
    input wire logic usr_cf_last,
    input wire logic usr_ratio_load,
    input wire fhi_pkg::fhi_ratio_t usr_ratio,
    output logic usr_res_valid,
    output fhi_pkg::fhi_res_t usr_res_i,
    output fhi_pkg::fhi_res_t usr_res_q,
    output logic usr_res_first,
    fhi_link.host link
);
    import fhi_pkg::*;

    fhi_host_s_t s_reg;
    fhi_host_s_t s_next;

    // ready seen this cycle allows the sample on the link next cycle
    assign usr_smp_ready = link.rdy && ce;
    assign usr_cf_ready = ce && (s_reg.st != HS_COMMIT);

    // ************************************************************
    // link driving
    // ************************************************************
    always_comb begin
        s_next = s_reg;
        if (ce) begin
            s_next.in_valid = 1'b0;
            s_next.cf_we = 1'b0;
            s_next.cf_commit = 1'b0;
            s_next.ratio_load = 1'b0;
            s_next.res_valid = 1'b0;
            if (usr_smp_valid && link.rdy) begin
                s_next.in_valid = 1'b1;
                s_next.in_i = usr_smp_i;
                s_next.in_q = usr_smp_q;
                s_next.in_first = usr_smp_first;
            end
            case (s_reg.st)
                HS_IDLE, HS_LOAD: begin
                    if (usr_cf_valid) begin
                        s_next.cf_we = 1'b1;
                        s_next.cf_data = usr_cf_data;
                        s_next.st = usr_cf_last ? HS_COMMIT : HS_LOAD;
                    end
                end
                HS_COMMIT: begin
                    s_next.cf_commit = 1'b1;
                    s_next.st = HS_IDLE;
                end
                default: begin
                    s_next.st = HS_IDLE;
                end
            endcase
            if (usr_ratio_load) begin
                s_next.ratio_load = 1'b1;
                s_next.ratio = usr_ratio;
            end
            if (link.out_valid) begin
                s_next.res_valid = 1'b1;
                s_next.res_i = link.out_i;
                s_next.res_q = link.out_q;
                s_next.res_first = link.out_first;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign link.in_valid = s_reg.in_valid;
    assign link.in_i = s_reg.in_i;
    assign link.in_q = s_reg.in_q;
    assign link.in_first = s_reg.in_first;
    assign link.cf_we = s_reg.cf_we;
    assign link.cf_data = s_reg.cf_data;
    assign link.cf_commit = s_reg.cf_commit;
    assign link.ratio_load = s_reg.ratio_load;
    assign link.ratio = s_reg.ratio;
    assign usr_res_valid = s_reg.res_valid;
    assign usr_res_i = s_reg.res_i;
    assign usr_res_q = s_reg.res_q;
    assign usr_res_first = s_reg.res_first;
endmodule // fhi_host_end

/* File: rtl/fhi_link.sv */
// link between the filter end and the sample source / result sink end
// assumes both ends share one clock; no clocking here
`timescale 1ns/1ps

interface fhi_link;
    logic rdy;
    logic in_valid;
    fhi_pkg::fhi_smp_t in_i;
    fhi_pkg::fhi_smp_t in_q;
    logic in_first;
    logic out_valid;
    fhi_pkg::fhi_res_t out_i;
    fhi_pkg::fhi_res_t out_q;
    logic out_first;
    fhi_pkg::fhi_coef_t cf_data;
    logic cf_we;
    logic cf_commit;
    fhi_pkg::fhi_ratio_t ratio;
    logic ratio_load;

    modport dev (
        output rdy, out_valid, out_i, out_q, out_first,
        input in_valid, in_i, in_q, in_first, cf_data, cf_we, cf_commit, ratio, ratio_load
    );

    modport host (
        input rdy, out_valid, out_i, out_q, out_first,
        output in_valid, in_i, in_q, in_first, cf_data, cf_we, cf_commit, ratio, ratio_load
    );
endinterface

/* File: rtl/fhi_pkg.sv */
// types shared by both ends of the fir host interface
// assumes fhi_defs.svh on the include path
`include "fhi_defs.svh"

package fhi_pkg;

    typedef logic signed [`FHI_DW-1:0] fhi_smp_t;
    typedef logic signed [`FHI_CW-1:0] fhi_coef_t;
    typedef logic signed [`FHI_OW-1:0] fhi_res_t;
    typedef logic [`FHI_RW-1:0] fhi_ratio_t;
    typedef fhi_smp_t [`FHI_HIST-1:0] fhi_hist_t;
    typedef fhi_coef_t [`FHI_TAPS-1:0] fhi_taps_t;

    typedef enum logic [1:0] {
        DS_WAIT = 2'b00,
        DS_RUN = 2'b01,
        DS_RECFG = 2'b11
    } fhi_dev_st_t;

    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_LOAD = 2'b01,
        HS_COMMIT = 2'b11
    } fhi_host_st_t;

    typedef struct packed {
        logic first;
        fhi_smp_t q;
        fhi_smp_t i;
    } fhi_word_t;

    typedef struct packed {
        fhi_dev_st_t st;
        logic coef_ok;
        fhi_taps_t taps;
        fhi_taps_t shadow;
        logic [4:0] wr_cnt;
        fhi_ratio_t ratio;
        fhi_ratio_t dec_cnt;
        logic [2:0] recfg_cnt;
        fhi_hist_t hist;
        logic out_valid;
        fhi_res_t out_i;
        fhi_res_t out_q;
        logic out_first;
    } fhi_dev_s_t;

    typedef struct packed {
        fhi_host_st_t st;
        logic in_valid;
        fhi_smp_t in_i;
        fhi_smp_t in_q;
        logic in_first;
        logic cf_we;
        fhi_coef_t cf_data;
        logic cf_commit;
        logic ratio_load;
        fhi_ratio_t ratio;
        logic res_valid;
        fhi_res_t res_i;
        fhi_res_t res_q;
        logic res_first;
    } fhi_host_s_t;

endpackage

/* File: tb/fhi_link_props.sv */
// checker of the fhi link: handshake, reload and stall relations
// assumes one clock; placed beside the link by the testbench
`timescale 1ns/1ps

module fhi_link_props (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    input wire logic rdy,
    input wire logic in_valid,
    input wire logic out_valid,
    input wire logic cf_we,
    input wire logic cf_commit,
    input wire logic ratio_load
);
    // ************************************************************
    // helper state
    // ************************************************************
    typedef struct packed {
        logic committed;
        logic [7:0] pend;
    } fhi_chk_s_t;
    fhi_chk_s_t s_reg;
    fhi_chk_s_t s_next;

    always_comb begin
        s_next = s_reg;
        if (ce) begin
            if (cf_commit) begin
                s_next.committed = 1'b1;
            end
            s_next.pend = s_reg.pend + {7'h00, in_valid} - {7'h00, out_valid};
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ************************************************************
    // properties
    // ************************************************************
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    chk_rdy_before_load: assert property (!s_reg.committed |-> !rdy)
        else $error("ready high before commit");
    chk_rdy_after_commit: assert property (cf_commit && ce && !s_reg.committed |-> ##[1:3] rdy)
        else $error("ready late after first commit");
    chk_ratio_stall: assert property (ratio_load && ce |=> !rdy [*4])
        else $error("ready high during reconfigure");
    chk_commit_pulse: assert property (cf_commit |=> !cf_commit)
        else $error("commit longer than one cycle");
    chk_we_then_commit: assert property ($fell(cf_we) |-> cf_commit)
        else $error("write strobe fell without commit");
    chk_commit_after_we: assert property (cf_commit |-> $past(cf_we))
        else $error("commit not after batch");
    chk_in_after_rdy: assert property (in_valid |-> $past(rdy))
        else $error("sample sent without ready");
    chk_out_has_cause: assert property (out_valid && ce |-> s_reg.pend != 8'h00)
        else $error("result without input sample");
    chk_ce_freeze: assert property (!ce |=> $stable(out_valid) && $stable(rdy) && $stable(in_valid))
        else $error("state moved with clock enable low");
endmodule // fhi_link_props

/* File: tb/fhi_tb.sv */
// testbench of both fhi ends joined by the link
// assumes the rtl package, link and both ends compiled before it
`timescale 1ns/1ps

module fhi_tb;
    import fhi_pkg::*;
    logic clock;
    logic nrst;
    logic ce;
    logic hs;
    logic reord;
    logic mc;
    logic hb;
    logic usr_smp_valid;
    logic usr_smp_first;
    logic usr_cf_valid;
    logic usr_cf_last;
    logic usr_ratio_load;
    fhi_smp_t usr_smp_i;
    fhi_smp_t usr_smp_q;
    fhi_coef_t usr_cf_data;
    fhi_ratio_t usr_ratio;
    logic usr_smp_ready;
    logic usr_cf_ready;
    logic usr_res_valid;
    logic usr_res_first;
    fhi_res_t usr_res_i;
    fhi_res_t usr_res_q;
    fhi_coef_t cf[$];
    fhi_coef_t tp[8];
    fhi_smp_t xh[16];
    fhi_res_t eq[$];
    fhi_res_t gq[$];
    logic ef[$];
    logic gf[$];
    int rr;
    int beat;
    int n_smp;
    int error_cnt;
    int compares;

    fhi_link i_fhi_link();
    fhi_dev_end i_fhi_dev_end (.clock(clock), .nrst(nrst), .ce(ce), .sync_clear(1'b0),
        .cfg_high_speed(hs), .cfg_multi_chan(mc), .cfg_reorder(reord),
        .cfg_symmetric(reord), .cfg_half_band(hb), .link(i_fhi_link.dev));
    fhi_host_end i_fhi_host_end (.clock(clock), .nrst(nrst), .ce(ce),
        .usr_smp_valid(usr_smp_valid), .usr_smp_ready(usr_smp_ready), .usr_smp_i(usr_smp_i),
        .usr_smp_q(usr_smp_q), .usr_smp_first(usr_smp_first), .usr_cf_valid(usr_cf_valid),
        .usr_cf_ready(usr_cf_ready), .usr_cf_data(usr_cf_data), .usr_cf_last(usr_cf_last),
        .usr_ratio_load(usr_ratio_load), .usr_ratio(usr_ratio), .usr_res_valid(usr_res_valid),
        .usr_res_i(usr_res_i), .usr_res_q(usr_res_q), .usr_res_first(usr_res_first),
        .link(i_fhi_link.host));
    fhi_link_props i_fhi_link_props (.clock(clock), .nrst(nrst), .ce(ce),
        .rdy(i_fhi_link.rdy), .in_valid(i_fhi_link.in_valid),
        .out_valid(i_fhi_link.out_valid), .cf_we(i_fhi_link.cf_we),
        .cf_commit(i_fhi_link.cf_commit), .ratio_load(i_fhi_link.ratio_load));

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic give_verdict();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic cmp_res(string what, fhi_res_t exp, fhi_res_t got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic cmp_bit(string what, logic exp, logic got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask

    function automatic fhi_res_t fir(input int s);
        fhi_res_t acc;
        acc = '0;
        for (int k = 0; k < 8; k++) begin
            acc = acc + fhi_res_t'(tp[k]) * fhi_res_t'(xh[k * s]);
        end
        return acc;
    endfunction

    function automatic void push_x(fhi_smp_t x);
        for (int k = 15; k > 0; k--) begin
            xh[k] = xh[k-1];
        end
        xh[0] = x;
    endfunction

    // one coefficient batch, strobe held to the last word
    task automatic load_cf();
        for (int i = 0; i < cf.size(); i++) begin
            usr_cf_data <= cf[i];
            usr_cf_last <= (i == cf.size() - 1);
            usr_cf_valid <= 1'b1;
            do @(negedge clock); while (usr_cf_ready !== 1'b1);
            @(posedge clock);
        end
        usr_cf_valid <= 1'b0;
        usr_cf_last <= 1'b0;
    endtask

    // samples back to back, clock enable dropped once in mid-stream
    task automatic stream(int n);
        fhi_res_t y;
        logic f;
        for (int i = 0; i < n; i++) begin
            if (i == 3) begin
                ce <= 1'b0;
                repeat (3) @(posedge clock);
                ce <= 1'b1;
            end
            n_smp++;
            f = mc && (i % 2 == 0);
            usr_smp_first <= f;
            usr_smp_i <= fhi_smp_t'((n_smp * 977) % 20011 - 10000);
            usr_smp_q <= fhi_smp_t'((n_smp * 613) % 17011 - 8000);
            usr_smp_valid <= 1'b1;
            do @(negedge clock); while (usr_smp_ready !== 1'b1);
            @(posedge clock);
            push_x(usr_smp_i);
            y = fir(mc ? 2 : 1);
            if (hs) begin
                push_x(usr_smp_q);
                eq.push_back(y);
                eq.push_back(fir(1));
                ef.push_back(f);
            end else if (beat % rr == 0) begin
                eq.push_back(y);
                ef.push_back(f);
            end
            beat++;
        end
        usr_smp_valid <= 1'b0;
        repeat (20) @(posedge clock);
    endtask

    task automatic check_results();
        cmp_res("result count", fhi_res_t'(eq.size()), fhi_res_t'(gq.size()));
        while (eq.size() > 0 && gq.size() > 0) begin
            cmp_res("result", eq.pop_front(), gq.pop_front());
        end
        while (ef.size() > 0 && gf.size() > 0) begin
            cmp_bit("first marker", ef.pop_front(), gf.pop_front());
        end
        eq.delete();
        gq.delete();
        ef.delete();
        gf.delete();
    endtask

    // ************************************************************
    // clock, monitor, watchdog
    // ************************************************************
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    always @(posedge clock) begin
        if (usr_res_valid === 1'b1 && ce === 1'b1) begin
            gf.push_back(usr_res_first);
            gq.push_back(usr_res_i);
            if (hs) begin
                gq.push_back(usr_res_q);
            end
        end
    end

    initial begin
        #100000;
        error_cnt++;
        give_verdict();
    end

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        {nrst, hs, reord, usr_smp_valid, usr_smp_first, usr_cf_valid} = '0;
        {usr_cf_last, usr_ratio_load, mc, hb} = '0;
        {usr_smp_i, usr_smp_q, usr_cf_data} = '0;
        usr_ratio = 4'h1;
        ce = 1'b1;
        xh = '{default: '0};
        {error_cnt, compares, beat, n_smp} = '0;
        rr = 1;
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        #1 cmp_bit("ready before coefficients", 1'b0, usr_smp_ready);
        @(posedge clock);
        cf = '{16'sh1, -16'sh2, 16'sh3, 16'sh4, -16'sh5, 16'sh6, 16'sh7, -16'sh8};
        foreach (tp[k]) tp[k] = cf[k];
        load_cf();
        stream(12);
        check_results();
        cf = '{16'sh2, 16'sh0, -16'sh1, 16'sh5, 16'sh3, -16'sh3, 16'sh1, 16'sh1};
        foreach (tp[k]) tp[k] = cf[k];
        load_cf();
        repeat (5) @(posedge clock);
        stream(6);
        check_results();
        usr_ratio <= 4'h2;
        usr_ratio_load <= 1'b1;
        @(posedge clock);
        usr_ratio_load <= 1'b0;
        repeat (3) @(posedge clock);
        #1 cmp_bit("ready in reconfigure", 1'b0, usr_smp_ready);
        rr = 2;
        beat = 0;
        @(posedge clock);
        stream(8);
        check_results();
        nrst <= 1'b0;
        hs <= 1'b1;
        reord <= 1'b1;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        xh = '{default: '0};
        rr = 1;
        @(posedge clock);
        cf = '{16'sh1, 16'sh2, 16'sh3, 16'sh4, 16'sh9, 16'sh9, 16'sh9, 16'sh9};
        tp = '{16'sh1, 16'sh2, 16'sh3, 16'sh4, 16'sh4, 16'sh3, 16'sh2, 16'sh1};
        load_cf();
        stream(8);
        check_results();
        nrst <= 1'b0;
        {hs, mc, hb} <= 3'b011;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        xh = '{default: '0};
        @(posedge clock);
        cf.delete();
        for (int i = 0; i < 15; i++) begin
            cf.push_back((i % 2 == 1) ? 16'sh0 : fhi_coef_t'(i / 2 + 1));
        end
        cf[13] = 16'sh9;
        tp = '{16'sh1, 16'sh2, 16'sh3, 16'sh4, 16'sh5, 16'sh6, 16'sh7, 16'sh9};
        load_cf();
        stream(8);
        check_results();
        give_verdict();
    end
endmodule // fhi_tb
